// >>> hw/cgs_top.sv
`timescale 1ns/1ps
// Contract
// - the mode strap is latched at power-up: high makes the shared pin a reference output, low makes it the halt input.
// - after the mode latch the mode pin stops being an input and drives a bus clock.
// - the bit-three strap is an input only at power-up, then drives a clock, and reads one when undriven.
// - the rate-pick strap chooses 24 MHz when high or 48 MHz when low, then its pin drives a bus clock.
// - strap bits zero and one are power-up inputs that read one when undriven.
// - after the strap latch the bit-two strap pin drives a reference clock.
// - while halt is low the true, complement and memory outputs zero to eleven stop low, oscillators run.
// - the free memory output keeps running under halt and stops only on power-down.
// - while power-down is low every output stops and the internal oscillator stops as well.
// - an enabled watchdog masks the power-down action.
// - the memory clock input is fanned out to all thirteen memory outputs under the gating.
// - the five-bit code is register bit two over strap bits three to zero and sets the rates.
// - with spread on, codes 10111, 11000 and 11111 use down-spread and all others centre-spread.
// - a control bit takes the code from the register when one and from the straps when zero.
// - a control bit enables spread modulation and resets to one.
module cgs_top #(
    parameter int STRAP_CYC = cgs_pkg::CGS_STRAP_CYC
) (
    input wire logic ref_clk, // 40 MHz system clock
    input wire logic resetn, // synchronous reset, power-up event
    input wire logic [3:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [3:0] avs_byteenable, // write byte lanes
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic pci5_mode_i, // mode strap / bus clock pin, in
    output logic pci5_mode_o, // same pin, out
    output logic pci5_mode_oe_n, // same pin, low while driven
    input wire logic refclk_out_a_i, // reference out or halt_n in
    output logic refclk_out_a_o, // same pin, out
    output logic refclk_out_a_oe_n, // same pin, low while driven
    input wire logic freq_strap_b3_i, // strap bit 3 / bus clock pin, in
    output logic freq_strap_b3_o, // same pin, out
    output logic freq_strap_b3_oe_n, // same pin, low while driven
    input wire logic usb_rate_pick_i, // rate strap / bus clock pin, in
    output logic usb_rate_pick_o, // same pin, out
    output logic usb_rate_pick_oe_n, // same pin, low while driven
    input wire logic freq_strap_b2_i, // strap bit 2 / reference pin, in
    output logic freq_strap_b2_o, // same pin, out
    output logic freq_strap_b2_oe_n, // same pin, low while driven
    input wire logic freq_strap_b1_i, // strap bit 1 / selectable usb pin, in
    output logic freq_strap_b1_o, // same pin, out
    output logic freq_strap_b1_oe_n, // same pin, low while driven
    input wire logic freq_strap_b0_i, // strap bit 0 / fixed usb pin, in
    output logic freq_strap_b0_o, // same pin, out
    output logic freq_strap_b0_oe_n, // same pin, low while driven
    input wire logic powerdown_n, // power-down request, active low
    input wire logic mem_clock_in, // memory clock source
    output logic [1:0] proc_clk_true, // true processor clocks
    output logic proc_clk_comp, // complementary processor clock
    output logic [11:0] mem_clock_out, // gated memory clocks
    output logic mem_clock_free_out, // free memory clock
    output logic [2:0] pci_clk_out, // dedicated bus clocks 2..4
    output logic spread_center, // centre-spread modulation active
    output logic spread_down // down-spread modulation active
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    cgs_pkg::cgs_state_t state_r;
    logic [15:0] cnt_r;
    logic mode_r;
    logic rate_r;
    logic [3:0] fs_strap_r;
    logic [7:0] ctrl_r;
    logic wdog_r;
    logic [2:0] ph_r;
    logic mem_s_r;
    logic [cgs_pkg::CGS_NOUT-1:0] en_r;
    logic [cgs_pkg::CGS_NOUT-1:0] out_r;
    logic shared_oe_n_r;
    logic pin_a_oe_n_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic spread_center_r;
    logic spread_down_r;

    // run also tells the shared pins to leave strap mode
    wire run = (state_r == cgs_pkg::CGS_RUN);
    wire window_end = (state_r == cgs_pkg::CGS_SAMPLE) && (cnt_r == 16'(STRAP_CYC - 1));

    // ----------------------------------------------------------------
    // power-up strap capture
    // ----------------------------------------------------------------
    // one window per reset: the counter parks once the run state is reached
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r <= cgs_pkg::CGS_SAMPLE;
            cnt_r <= 16'h0000;
        end else if (window_end) begin
            state_r <= cgs_pkg::CGS_RUN;
        end else if (!run) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // latched once at the window end; nothing reloads them until reset
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mode_r <= 1'b1;
            rate_r <= 1'b1;
            fs_strap_r <= 4'hf;
        end else if (window_end) begin
            mode_r <= pci5_mode_i;
            rate_r <= usb_rate_pick_i;
            fs_strap_r <= {freq_strap_b3_i, freq_strap_b2_i, freq_strap_b1_i,
                freq_strap_b0_i};
        end
    end

    // pins stay undriven through the window so pull-ups set undriven straps to one
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            shared_oe_n_r <= 1'b1;
            pin_a_oe_n_r <= 1'b1;
        end else begin
            shared_oe_n_r <= !run;
            pin_a_oe_n_r <= !(run && mode_r);
        end
    end

    // ----------------------------------------------------------------
    // frequency code and spread selection
    // ----------------------------------------------------------------
    // limitation: a new code applies at once; stepped rate changes are not modelled
    wire [3:0] code_low = ctrl_r[cgs_pkg::CGS_CTRL_SRC] ?
        ctrl_r[cgs_pkg::CGS_CTRL_FS_LSB+:4] : fs_strap_r;
    wire [4:0] code = {ctrl_r[cgs_pkg::CGS_CTRL_CODE_MSB], code_low};
    wire spread_on = ctrl_r[cgs_pkg::CGS_CTRL_SSC];
    // three codes use down-spread, all others centre-spread
    wire down_code = (code == cgs_pkg::CGS_DOWN_A) || (code == cgs_pkg::CGS_DOWN_B)
        || (code == cgs_pkg::CGS_DOWN_C);
    wire [15:0] cpu_rate = cgs_pkg::CGS_CPU_TBL[code];
    wire [15:0] pci_rate = cgs_pkg::CGS_PCI_TBL[code];

    // spread is only reported; the modulator sits outside this block
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            spread_center_r <= 1'b0;
            spread_down_r <= 1'b0;
        end else begin
            spread_center_r <= spread_on && !down_code;
            spread_down_r <= spread_on && down_code;
        end
    end

    // ----------------------------------------------------------------
    // stop and power-down gating
    // ----------------------------------------------------------------
    // halt only exists when the shared pin was strapped as an input
    wire halt_act = run && !mode_r && !refclk_out_a_i;
    // watchdog enable only masks power-down; its counter is not part of this block
    wire pwrdn_act = !powerdown_n && !wdog_r;
    // the oscillator only parks once every output sits low, else a
    // frozen high phase could never be gated off cleanly
    wire osc_stop = pwrdn_act && (en_r == '0);
    wire [cgs_pkg::CGS_NOUT-1:0] src;
    wire [cgs_pkg::CGS_NOUT-1:0] stop_req;

    // processor pair and its complement run on the fastest phase bit
    assign src[1:0] = {2{ph_r[0]}};
    assign src[2] = ~ph_r[0];
    // memory outputs follow the sampled memory input, two cycles late
    assign src[15:3] = {13{mem_s_r}};
    // reference outputs on the slowest phase bit, bus and usb on the middle one
    assign src[17:16] = {2{ph_r[2]}};
    assign src[24:18] = {7{ph_r[1]}};
    // the selectable usb output follows the rate strap latched at power-up
    assign src[25] = rate_r ? ph_r[2] : ph_r[1];
    // power-down and the strap window stop every output, halt only its group
    wire all_stop = !run || pwrdn_act;
    assign stop_req = {cgs_pkg::CGS_NOUT{all_stop}}
        | (cgs_pkg::CGS_HALT_GRP & {cgs_pkg::CGS_NOUT{halt_act}});

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ph_r <= 3'h0;
            mem_s_r <= 1'b0;
        end else begin
            // sampled once so every fan-out copy sees the same edge
            mem_s_r <= mem_clock_in;
            if (!osc_stop) begin
                ph_r <= ph_r + 3'h1;
            end
        end
    end

    // enable moves only while its source is low, so the first and last
    // pulses passed are whole
    for (genvar i = 0; i < cgs_pkg::CGS_NOUT; i++) begin : g_gate
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                en_r[i] <= 1'b0;
                out_r[i] <= 1'b0;
            end else begin
                if (!src[i]) begin
                    en_r[i] <= !stop_req[i];
                end
                out_r[i] <= src[i] && en_r[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // register slave
    // ----------------------------------------------------------------
    wire req = avs_read || avs_write;
    wire wr_go = avs_write && !wait_r;
    wire hit_ctrl = (avs_address == cgs_pkg::CGS_OFF_CTRL);
    wire hit_stat = (avs_address == cgs_pkg::CGS_OFF_STAT);
    wire hit_freq = (avs_address == cgs_pkg::CGS_OFF_FREQ);
    wire hit_wdog = (avs_address == cgs_pkg::CGS_OFF_WDOG);
    // status word, one field per line from bit 16 down to bit 0
    wire [31:0] stat_word = {
        15'h0000,
        osc_stop,
        pwrdn_act,
        halt_act,
        spread_down_r,
        spread_center_r,
        code,
        fs_strap_r,
        rate_r,
        mode_r,
        run
    };
    // unmapped offsets read zero and raise no error
    wire [31:0] rd_mux = hit_ctrl ? {24'h00_0000, ctrl_r} :
        hit_stat ? stat_word :
        hit_freq ? {pci_rate, cpu_rate} :
        hit_wdog ? {31'h0000_0000, wdog_r} : 32'h0000_0000;

    // one wait cycle per access, then the answer edge
    // a request still held after the answer edge starts a fresh access
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= !(req && wait_r);
            if (req && wait_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // both registers live in byte lane zero; the other lanes are ignored
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctrl_r <= cgs_pkg::CGS_CTRL_RST;
            wdog_r <= cgs_pkg::CGS_WDOG_RST;
        end else if (wr_go && avs_byteenable[0]) begin
            // bit zero has no function and always reads back zero
            if (hit_ctrl) begin
                ctrl_r <= {avs_writedata[7:1], 1'b0};
            end
            if (hit_wdog) begin
                wdog_r <= avs_writedata[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // the bus answer comes from registers, one wait cycle after the request
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign proc_clk_true = out_r[1:0];
    assign proc_clk_comp = out_r[2];
    assign mem_clock_out = out_r[14:3];
    assign mem_clock_free_out = out_r[15];
    // shared pins: strap inputs in the window, clock outputs after it, pin a only when mode_r is high
    assign refclk_out_a_o = out_r[16];
    assign refclk_out_a_oe_n = pin_a_oe_n_r;
    assign freq_strap_b2_o = out_r[17];
    assign freq_strap_b2_oe_n = shared_oe_n_r;
    assign freq_strap_b3_o = out_r[18];
    assign freq_strap_b3_oe_n = shared_oe_n_r;
    assign usb_rate_pick_o = out_r[19];
    assign usb_rate_pick_oe_n = shared_oe_n_r;
    assign pci_clk_out = out_r[22:20];
    assign pci5_mode_o = out_r[23];
    assign pci5_mode_oe_n = shared_oe_n_r;
    assign freq_strap_b0_o = out_r[24];
    assign freq_strap_b0_oe_n = shared_oe_n_r;
    assign freq_strap_b1_o = out_r[25];
    assign freq_strap_b1_oe_n = shared_oe_n_r;
    assign spread_center = spread_center_r;
    assign spread_down = spread_down_r;

endmodule

// >>> hw/cgs_pkg.sv
package cgs_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CGS_CLK_MHZ = 40;
    localparam int CGS_STRAP_NS = 1000;
    // least time, rounded up to whole cycles
    localparam int CGS_STRAP_CYC = (CGS_STRAP_NS * CGS_CLK_MHZ + 999) / 1000;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [3:0] CGS_OFF_CTRL = 4'h0;
    localparam logic [3:0] CGS_OFF_STAT = 4'h4;
    localparam logic [3:0] CGS_OFF_FREQ = 4'h8;
    localparam logic [3:0] CGS_OFF_WDOG = 4'hc;

    localparam int CGS_CTRL_FS_LSB = 4;
    localparam int CGS_CTRL_SRC = 3;
    localparam int CGS_CTRL_CODE_MSB = 2;
    localparam int CGS_CTRL_SSC = 1;
    localparam logic [7:0] CGS_CTRL_RST = 8'h42;
    localparam logic CGS_WDOG_RST = 1'b0;

    // ----------------------------------------------------------------
    // frequency code
    // ----------------------------------------------------------------
    localparam logic [4:0] CGS_DOWN_A = 5'h07 | 5'h10;
    localparam logic [4:0] CGS_DOWN_B = 5'h18;
    localparam logic [4:0] CGS_DOWN_C = 5'h1f;

    // processor and bus rate per code, in units of 0.1 MHz
    localparam logic [15:0] CGS_CPU_TBL [32] = '{
        16'h04d8, 16'h02ee, 16'h0341, 16'h029c, 16'h0406, 16'h0460, 16'h0535, 16'h03e8,
        16'h04b0, 16'h047e, 16'h044c, 16'h041a, 16'h0578, 16'h05dc, 16'h04d8, 16'h0535,
        16'h0384, 16'h039d, 16'h03b6, 16'h03cf, 16'h03f7, 16'h04f6, 16'h0555, 16'h03e8,
        16'h04b0, 16'h0497, 16'h04c4, 16'h0433, 16'h05aa, 16'h060e, 16'h0514, 16'h0535};
    localparam logic [15:0] CGS_PCI_TBL [32] = '{
        16'h019d, 16'h0177, 16'h01a1, 16'h014e, 16'h0157, 16'h0175, 16'h01bc, 16'h014d,
        16'h0190, 16'h017f, 16'h016f, 16'h015e, 16'h015e, 16'h0177, 16'h0136, 16'h014d,
        16'h012c, 16'h0134, 16'h013d, 16'h0145, 16'h0152, 16'h01a7, 16'h0155, 16'h014d,
        16'h0190, 16'h0188, 16'h0197, 16'h0166, 16'h016b, 16'h0183, 16'h0145, 16'h014d};

    // ----------------------------------------------------------------
    // gated outputs: 0..1 true, 2 comp, 3..14 mem, 15 mem free,
    // 16..17 ref, 18..23 bus, 24 fixed usb, 25 selectable usb
    // ----------------------------------------------------------------
    localparam int CGS_NOUT = 26;
    localparam logic [25:0] CGS_HALT_GRP = 26'h000_7fff;

    typedef enum logic {
        CGS_SAMPLE = 1'b0,
        CGS_RUN = 1'b1
    } cgs_state_t;

endpackage

// >>> testbench/cgs_monitor.sv
`timescale 1ns/1ps
module cgs_monitor #(
    parameter int STRAP_CYC = 4
) (
    input wire logic ref_clk, // clock
    input wire logic resetn, // power-up reset
    input wire logic [3:0] avs_address, // bus address
    input wire logic avs_write, // bus write
    input wire logic [3:0] avs_byteenable, // write lanes
    input wire logic [31:0] avs_writedata, // write data
    input wire logic avs_waitrequest, // bus stall
    input wire logic pci5_mode_oe_n, // mode pin enable
    input wire logic refclk_out_a_i, // halt pin level
    input wire logic refclk_out_a_oe_n, // halt pin enable
    input wire logic powerdown_n, // power-down request
    input wire logic mem_clock_in, // memory source
    input wire logic [1:0] proc_clk_true, // true clocks
    input wire logic proc_clk_comp, // complement clock
    input wire logic [11:0] mem_clock_out, // gated memory
    input wire logic mem_clock_free_out, // free memory
    input wire logic [2:0] pci_clk_out, // bus clocks
    input wire logic freq_strap_b2_o // reference pin
);
    logic dog_r;
    logic [7:0] cyc_r;
    wire run = !pci5_mode_oe_n;
    wire halt = refclk_out_a_oe_n && !refclk_out_a_i;
    wire pwrdn = !powerdown_n && !dog_r;
    // watchdog enable mirrored from the bus, as it masks power-down
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dog_r <= 1'b0;
            cyc_r <= 8'h00;
        end else begin
            cyc_r <= (cyc_r == 8'hff) ? cyc_r : cyc_r + 8'h01;
            if (avs_write && !avs_waitrequest && avs_byteenable[0]
                && avs_address == cgs_pkg::CGS_OFF_WDOG) begin
                dog_r <= avs_writedata[0];
            end
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    strap_win_a: assert property ($fell(pci5_mode_oe_n)
        |-> cyc_r >= STRAP_CYC - 1 && cyc_r <= STRAP_CYC + 3) else $error("strap window length");
    strap_hold_a: assert property (run |=> run) else $error("pin went back to input");
    halt_stop_a: assert property ((run && halt)[*8]
        |-> proc_clk_true == 2'b00 && !proc_clk_comp && mem_clock_out == 12'h000)
        else $error("clocks run under halt");
    free_run_a: assert property ((run && halt && powerdown_n)[*8]
        |-> mem_clock_free_out != $past(mem_clock_free_out, 2)) else $error("free clock stopped");
    pwrdn_stop_a: assert property (pwrdn[*8]
        |-> {proc_clk_true, proc_clk_comp, mem_clock_out, mem_clock_free_out, pci_clk_out}
        == 19'h0_0000) else $error("clocks run in power-down");
    dog_mask_a: assert property ((run && !powerdown_n && dog_r)[*8]
        |-> pci_clk_out[0] != $past(pci_clk_out[0], 2)) else $error("power-down not masked");
    fan_out_a: assert property ((run && !halt && powerdown_n)[*8]
        |-> mem_clock_free_out == $past(mem_clock_in, 2)
        && mem_clock_out == {12{mem_clock_free_out}}) else $error("memory fan-out wrong");
    bus_pulse_a: assert property ($rose(pci_clk_out[0]) |=> pci_clk_out[0])
        else $error("short bus clock pulse");
    ref_pulse_a: assert property ($rose(freq_strap_b2_o) |-> freq_strap_b2_o[*4])
        else $error("short reference pulse");
    halt_c: cover property ((run && halt)[*8]);
    pwrdn_c: cover property (pwrdn[*8]);
    dog_c: cover property ((run && !powerdown_n && dog_r)[*8]);
endmodule

// >>> testbench/cgs_board.sv
`timescale 1ns/1ps
module cgs_board (
    input wire logic [6:0] oe_n, // device pin enables, low while driving
    input wire logic [6:0] dev_o, // device pin levels
    input wire logic [6:0] drv_en, // board or chipset drives the pin
    input wire logic [6:0] drv_val, // level it drives
    output logic [6:0] pin // resolved wire
);
    // every shared pin has a pull-up, so a released strap reads one
    assign pin = (~oe_n & dev_o) | (oe_n & ((drv_en & drv_val) | ~drv_en));
endmodule

// >>> testbench/cgs_top_tb.sv
`timescale 1ns/1ps
module cgs_top_tb;
    localparam int STRAP_CYC = 4;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0;
    logic powerdown_n = 1'b1;
    logic [1:0] mck = 2'h0;
    logic [6:0] drv_en = 7'h0d;
    logic [6:0] drv_val = 7'h00;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [6:0] pin_i;
    wire [6:0] pin_o;
    wire [6:0] pin_oe_n;
    wire [1:0] proc_clk_true;
    wire proc_clk_comp;
    wire [11:0] mem_clock_out;
    wire mem_clock_free_out;
    wire [2:0] pci_clk_out;
    wire spread_center;
    wire spread_down;
    wire [4:0] mon = {pin_o[4], mem_clock_out[0], pin_o[5], mem_clock_free_out, proc_clk_true[0]};
    logic [4:0] mon_d = 5'h00;
    int tg[5] = '{default: 0};
    int t0[5];
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] q;
    logic [4:0] c;
    logic s;
    logic [31:0] f;
    logic [1:0] p;
    logic [6:0] b;
    // code, spread enable, bus and processor rate, {down, centre}
    logic [39:0] rows [8] = '{{5'h00, 1'b1, 32'h019d_04d8, 2'b01},
        {5'h07, 1'b1, 32'h014d_03e8, 2'b01}, {5'h08, 1'b1, 32'h0190_04b0, 2'b01},
        {5'h10, 1'b1, 32'h012c_0384, 2'b01}, {5'h17, 1'b1, 32'h014d_03e8, 2'b10},
        {5'h18, 1'b1, 32'h0190_04b0, 2'b10}, {5'h1f, 1'b1, 32'h014d_0535, 2'b10},
        {5'h1f, 1'b0, 32'h014d_0535, 2'b00}};

    cgs_top #(.STRAP_CYC(STRAP_CYC)) i_cgs_top (.ref_clk(ref_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pci5_mode_i(pin_i[0]), .pci5_mode_o(pin_o[0]), .pci5_mode_oe_n(pin_oe_n[0]),
        .refclk_out_a_i(pin_i[1]), .refclk_out_a_o(pin_o[1]), .refclk_out_a_oe_n(pin_oe_n[1]),
        .freq_strap_b3_i(pin_i[2]), .freq_strap_b3_o(pin_o[2]), .freq_strap_b3_oe_n(pin_oe_n[2]),
        .usb_rate_pick_i(pin_i[3]), .usb_rate_pick_o(pin_o[3]), .usb_rate_pick_oe_n(pin_oe_n[3]),
        .freq_strap_b2_i(pin_i[4]), .freq_strap_b2_o(pin_o[4]), .freq_strap_b2_oe_n(pin_oe_n[4]),
        .freq_strap_b1_i(pin_i[5]), .freq_strap_b1_o(pin_o[5]), .freq_strap_b1_oe_n(pin_oe_n[5]),
        .freq_strap_b0_i(pin_i[6]), .freq_strap_b0_o(pin_o[6]), .freq_strap_b0_oe_n(pin_oe_n[6]),
        .powerdown_n(powerdown_n), .mem_clock_in(mck[1]), .proc_clk_true(proc_clk_true),
        .proc_clk_comp(proc_clk_comp), .mem_clock_out(mem_clock_out),
        .mem_clock_free_out(mem_clock_free_out), .pci_clk_out(pci_clk_out),
        .spread_center(spread_center), .spread_down(spread_down));
    cgs_board i_cgs_board (.oe_n(pin_oe_n), .dev_o(pin_o), .drv_en(drv_en), .drv_val(drv_val),
        .pin(pin_i));

    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        mon_d <= mon;
        mck <= mck + 2'h1;
        for (int k = 0; k < 5; k++) begin
            if (mon[k] !== mon_d[k]) tg[k] <= tg[k] + 1;
        end
    end

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low; bounded wait
    task automatic wr(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        if (n == 40) chk(32'h1, 32'h0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        wr(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic watch();
        t0 = tg;
        repeat (16) @(posedge ref_clk);
        for (int k = 0; k < 5; k++) t0[k] = tg[k] - t0[k];
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk(pin_oe_n, 32'h7f);
        repeat (STRAP_CYC) @(posedge ref_clk);
        drv_en <= 7'h00;
        rd(4'h0);
        chk(q, 32'h42);
        rd(4'hc);
        chk(q, 32'h0);
        repeat (8) @(posedge ref_clk);
        chk(pin_oe_n, 32'h02);
        rd(4'h4);
        chk(q & 32'h7f, 32'h39);
        rd(4'h8);
        chk(q, 32'h014d_03e8);
        watch();
        chk(t0[2], 8);
        chk(t0[3], 8);
        chk(t0[4], 4);
        b = {pin_o[6], pin_o[3:2], pin_o[0], pci_clk_out};
        chk(b, {7{b[0]}});
        chk({proc_clk_comp, proc_clk_true[1]}, {~proc_clk_true[0], proc_clk_true[0]});
        repeat (2) @(posedge ref_clk);
        chk({pin_o[6], pin_o[3:2], pin_o[0], pci_clk_out}, 7'(~b));
        drv_en <= 7'h02;
        repeat (10) @(posedge ref_clk);
        watch();
        chk(t0[0], 0);
        chk(t0[3], 0);
        chk(t0[1], 8);
        drv_en <= 7'h00;
        powerdown_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        watch();
        chk(t0[1] + t0[2] + t0[4], 0);
        rd(4'h4);
        chk(q & 32'h1_0000, 32'h1_0000);
        wr(1'b1, 4'hc, 32'h1, 4'h1);
        repeat (10) @(posedge ref_clk);
        watch();
        chk(t0[0], 16);
        wr(1'b1, 4'hc, 32'h0, 4'h1);
        powerdown_n <= 1'b1;
        wr(1'b1, 4'h2, 32'hff, 4'hf);
        rd(4'h2);
        chk(q, 32'h0);
        wr(1'b1, 4'h0, 32'h0, 4'h0);
        rd(4'h0);
        chk(q, 32'h42);
        for (int i = 0; i < 8; i++) begin
            {c, s, f, p} = rows[i];
            wr(1'b1, 4'h0, {24'h0, c[3:0], 1'b1, c[4], s, 1'b0}, 4'h1);
            rd(4'h8);
            chk(q, f);
            rd(4'h4);
            chk({q[13:12], q[11:7]}, {p, c});
            chk({spread_down, spread_center}, p);
        end
        chk(q & 32'h7f, 32'h39);
        resetn <= 1'b0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (STRAP_CYC + 12) @(posedge ref_clk);
        chk(pin_oe_n, 32'h0);
        rd(4'h4);
        chk(q & 32'h7f, 32'h7f);
        rd(4'h8);
        chk(q, 32'h014d_0535);
        watch();
        chk(t0[2], 4);
        chk(pin_o[1], pin_o[4]);
        summarize();
    end
    initial begin
        #(25 * 8000);
        num_errors++;
        summarize();
    end
endmodule

bind cgs_top cgs_monitor #(.STRAP_CYC(STRAP_CYC)) i_cgs_monitor (.ref_clk(ref_clk),
    .resetn(resetn), .avs_address(avs_address), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .pci5_mode_oe_n(pci5_mode_oe_n),
    .refclk_out_a_i(refclk_out_a_i), .refclk_out_a_oe_n(refclk_out_a_oe_n),
    .powerdown_n(powerdown_n), .mem_clock_in(mem_clock_in), .proc_clk_true(proc_clk_true),
    .proc_clk_comp(proc_clk_comp), .mem_clock_out(mem_clock_out),
    .mem_clock_free_out(mem_clock_free_out), .pci_clk_out(pci_clk_out),
    .freq_strap_b2_o(freq_strap_b2_o));
